/* File: verilog/odt_cfg.svh */
// constants for the termination latency control block
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

// mode register field positions
`define MR0_DLL_PD_BIT 12
`define MR1_AL_HI 4
`define MR1_AL_LO 3
`define MR1_RTT_B2 9
`define MR1_RTT_B1 6
`define MR1_RTT_B0 2
`define MR2_RTTWR_HI 10
`define MR2_RTTWR_LO 9

// additive latency encodings of the two-bit field
`define AL_SEL_ZERO 2'h0
`define AL_SEL_CL1 2'h1
`define AL_SEL_CL2 2'h2

// term_on_latency = term_off_latency = write latency minus this
`define LAT_OFFSET 6'h02

// pin hold figures in clock cycles
`define SHORT_BURST_HOLD 3'h4
`define LONG_BURST_HOLD 3'h6

// clock and analog delays in picoseconds
`define CLK_PERIOD_PS 10000
`define ASYNC_ON_MIN_PS 2000
`define ASYNC_ON_MAX_PS 8500
`define ASYNC_OFF_MAX_PS 8500
// longest time rounds down, but never below one cycle
`define ASYNC_DLY_CYC \
	(((`ASYNC_OFF_MAX_PS) / (`CLK_PERIOD_PS)) < 1 ? 1 : \
	((`ASYNC_OFF_MAX_PS) / (`CLK_PERIOD_PS)))

// depth of the pin delay line, enough for the largest latency
`define DELAY_DEPTH 32

// reset values
`define STRENGTH_OFF 3'h0
`define HOLD_NONE 3'h0

`endif

/* File: verilog/odt_pkg.sv */
// types shared by the termination latency control block
`default_nettype none
`include "odt_cfg.svh"

package odt_pkg;

	// latency in clock cycles
	typedef logic [4:0] lat_t;

	// mode register images and latencies, carried together
	typedef struct packed {
		logic [15:0] mr0;
		logic [15:0] mr1;
		logic [15:0] mr2;
		logic [4:0] casLat;
		logic [3:0] casWriteLat;
	} mode_regs_t;

	// whole state of the main block
	typedef struct packed {
		logic termOn;
		logic [2:0] strength;
		logic sync;
		logic prevPin;
		logic [2:0] holdLeft;
		logic holdErr;
	} term_state_t;

	// whole state of the delay line
	typedef struct packed {
		logic [`DELAY_DEPTH-1:0] taps;
	} delay_state_t;

endpackage : odt_pkg

`default_nettype wire

/* File: verilog/odt_delay_line.sv */
// variable-tap delay line for the sampled termination pin
`timescale 1ns/1ps
`default_nettype none
`include "odt_cfg.svh"

module odt_delay_line
	import odt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	input wire lat_t lat,
	output logic dout
);

	delay_state_t s; // current taps
	delay_state_t next_s; // next taps

	////////////////////////////////////////////////////////////////////
	// shift every cycle; taps[j] holds the pin from j+1 edges ago
	always_comb begin
		next_s = s;
		next_s.taps = {s.taps[`DELAY_DEPTH-2:0], din};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// lat of zero is never programmed; guard it to the first tap anyway
	always_comb begin
		if (lat == 5'h00) begin
			dout = s.taps[0];
		end else begin
			dout = s.taps[lat - 5'h01];
		end
	end

endmodule : odt_delay_line

`default_nettype wire

/* File: verilog/ddr3_termination_latency_control.sv */
// termination on/off timing in synchronous and asynchronous mode
`timescale 1ns/1ps
`default_nettype none
`include "odt_cfg.svh"

// Behaviour
// - sync: on term_on_latency cycles after high
// - sync: off term_off_latency cycles after low
// - both latencies equal write latency minus two
// - sync pin copy delayed by additive latency
// - holds count from high or write
// - async in DLL-off power-down or resync
// - async: no additive latency delay applied
// - async on within 2 to 8.5 ns; here one 10 ns clock cycle
// - async off within 8.5 ns; here one 10 ns clock cycle
// - sync when DLL locked, value enabled and not in DLL-off power-down
// - nominal strength from three mode bits
module ddr3_termination_latency_control
	import odt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic termPin,
	input wire logic writeCmd,
	input wire logic writeChop,
	input wire logic prechargePd,
	input wire logic dllLocked,
	input wire mode_regs_t modeRegs,
	output logic termEnable,
	output logic [2:0] termStrength,
	output logic syncMode,
	output logic holdViolation
);

	////////////////////////////////////////////////////////////////////
	// additive latency in cycles from its two-bit field
	function automatic logic [4:0] al_cycles(mode_regs_t m);
		logic [1:0] sel;
		sel = m.mr1[`MR1_AL_HI:`MR1_AL_LO];
		unique case (sel)
			`AL_SEL_CL1: al_cycles = m.casLat - 5'h01;
			`AL_SEL_CL2: al_cycles = m.casLat - 5'h02;
			default: al_cycles = 5'h00; // zero and reserved
		endcase
	endfunction : al_cycles

	// shared on/off latency: cwl + al - 2
	function automatic lat_t term_latency(mode_regs_t m);
		logic [5:0] sum;
		sum = {2'h0, m.casWriteLat} + {1'b0, al_cycles(m)} - `LAT_OFFSET;
		term_latency = sum[4:0];
	endfunction : term_latency

	////////////////////////////////////////////////////////////////////
	term_state_t s; // registered state
	term_state_t next_s; // next state
	lat_t lat; // current term latency
	logic delayedPin; // pin after the full sync latency
	logic [2:0] rttNom; // nominal termination code
	logic [1:0] rttWr; // write termination code
	logic enabled; // some termination value programmed
	logic asyncWanted; // DLL not usable for timing
	logic [2:0] holdDec; // remaining hold, aged by one
	logic [2:0] holdNew; // hold started this edge

	assign lat = term_latency(modeRegs);

	// one line covers additive and cas write parts together
	odt_delay_line delayLine (
		.clk(clk),
		.rst(rst),
		.din(termPin),
		.lat(lat),
		.dout(delayedPin)
	);

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_s = s;
		rttNom = {modeRegs.mr1[`MR1_RTT_B2], modeRegs.mr1[`MR1_RTT_B1],
			modeRegs.mr1[`MR1_RTT_B0]};
		rttWr = modeRegs.mr2[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
		enabled = (rttNom != 3'h0) || (rttWr != 2'h0);
		// DLL off in precharge power-down, or still relocking
		asyncWanted = (prechargePd && !modeRegs.mr0[`MR0_DLL_PD_BIT])
			|| !dllLocked;
		next_s.sync = enabled && !asyncWanted;
		if (!enabled) begin
			next_s.termOn = 1'b0;
		end else if (s.sync) begin
			// latency counted purely by the delay line
			next_s.termOn = delayedPin;
		end else begin
			// one cycle: the 8.5 ns window is shorter than a cycle, so the one-cycle minimum applies
			next_s.termOn = termPin;
		end
		// strength only reported while terminating
		next_s.strength = next_s.termOn ? rttNom : `STRENGTH_OFF;
		// hold checker: counts edges the pin still has to stay high
		holdDec = (s.holdLeft != `HOLD_NONE) ? s.holdLeft - 3'h1
			: `HOLD_NONE;
		holdNew = `HOLD_NONE;
		if (termPin && !s.prevPin) begin
			holdNew = `SHORT_BURST_HOLD - 3'h1;
		end
		if (writeCmd && termPin) begin
			if (writeChop) begin
				if (`SHORT_BURST_HOLD - 3'h1 > holdNew) begin
					holdNew = `SHORT_BURST_HOLD - 3'h1;
				end
			end else begin
				holdNew = `LONG_BURST_HOLD - 3'h1;
			end
		end
		// later-ending hold wins
		if (termPin) begin
			next_s.holdLeft = (holdDec > holdNew) ? holdDec : holdNew;
		end else begin
			next_s.holdLeft = `HOLD_NONE;
		end
		next_s.holdErr = !termPin && (s.holdLeft != `HOLD_NONE);
		next_s.prevPin = termPin;
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign termEnable = s.termOn;
	assign termStrength = s.strength;
	assign syncMode = s.sync;
	assign holdViolation = s.holdErr;

	////////////////////////////////////////////////////////////////////
	// helper history and counter for the checks below
	// the pin history is kept apart from the delay line, so the latency
	// checks do not lean on the very logic that they guard
	logic [`DELAY_DEPTH-1:0] pinHist; // bit j: pin sampled j+1 edges ago
	logic [4:0] syncRun; // edges spent in sync mode

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinHist <= '0;
			syncRun <= 5'h00;
		end else begin
			pinHist <= {pinHist[`DELAY_DEPTH-2:0], termPin};
			syncRun <= !s.sync ? 5'h00
				: (syncRun == 5'h1F ? syncRun : syncRun + 5'h01);
		end
	end

	// the output seen at an edge was set one edge earlier from the pin
	// taken lat edges before that, so the history tap is lat itself
	a_sync_on_lat: assert property (@(posedge clk) disable iff (rst)
		$past(syncMode) && $past(enabled) && $stable(lat) && pinHist[lat]
		|-> termEnable)
		else $error("sync turn-on latency wrong");

	a_sync_off_lat: assert property (@(posedge clk) disable iff (rst)
		$past(syncMode) && $past(enabled) && $stable(lat) && !pinHist[lat]
		|-> !termEnable)
		else $error("sync turn-off latency wrong");

	// cwl 5 and no additive latency: lat 3, pin seen four edges back
	a_no_al_lat: assert property (@(posedge clk) disable iff (rst)
		syncMode && syncRun > 5'h05 && modeRegs.casWriteLat == 4'h5
		&& modeRegs.mr1[`MR1_AL_HI:`MR1_AL_LO] == `AL_SEL_ZERO
		&& $stable(modeRegs) |-> termEnable == $past(termPin, 4))
		else $error("latency with zero additive latency wrong");

	// cwl 5, cl 6, al = cl - 1: lat 8, pin seen nine edges back
	a_al_delay: assert property (@(posedge clk) disable iff (rst)
		syncMode && syncRun > 5'h0A && modeRegs.casWriteLat == 4'h5
		&& modeRegs.casLat == 5'h06
		&& modeRegs.mr1[`MR1_AL_HI:`MR1_AL_LO] == `AL_SEL_CL1
		&& $stable(modeRegs) |-> termEnable == $past(termPin, 9))
		else $error("additive latency not applied");

	a_async_direct: assert property (@(posedge clk) disable iff (rst)
		!$past(syncMode) && !syncMode && $past(enabled)
		|-> termEnable == $past(termPin, `ASYNC_DLY_CYC))
		else $error("async pin not followed directly");

	a_async_on: assert property (@(posedge clk) disable iff (rst)
		!syncMode && enabled && termPin |=> termEnable)
		else $error("async turn-on late");

	a_async_off: assert property (@(posedge clk) disable iff (rst)
		!syncMode && !termPin |=> !termEnable)
		else $error("async turn-off late");

	a_async_select: assert property (@(posedge clk) disable iff (rst)
		!dllLocked || (prechargePd && !modeRegs.mr0[`MR0_DLL_PD_BIT])
		|=> !syncMode)
		else $error("sync mode kept while DLL unusable");

	a_sync_select: assert property (@(posedge clk) disable iff (rst)
		dllLocked && !prechargePd
		&& modeRegs.mr1[`MR1_RTT_B1] |=> syncMode)
		else $error("sync mode not selected");

	a_nom_strength: assert property (@(posedge clk) disable iff (rst)
		termEnable |-> termStrength == {$past(modeRegs.mr1[`MR1_RTT_B2]),
		$past(modeRegs.mr1[`MR1_RTT_B1]), $past(modeRegs.mr1[`MR1_RTT_B0])})
		else $error("strength code wrong");

	a_off_unset: assert property (@(posedge clk) disable iff (rst)
		{modeRegs.mr1[`MR1_RTT_B2], modeRegs.mr1[`MR1_RTT_B1],
		modeRegs.mr1[`MR1_RTT_B0]} == 3'h0
		&& modeRegs.mr2[`MR2_RTTWR_HI:`MR2_RTTWR_LO] == 2'h0
		|=> !termEnable && termStrength == 3'h0)
		else $error("termination on while disabled");

	a_short_hold: assert property (@(posedge clk) disable iff (rst)
		termPin && !$past(termPin) ##1 termPin ##1 !termPin
		|=> holdViolation)
		else $error("short pin pulse not flagged");

	a_write_hold: assert property (@(posedge clk) disable iff (rst)
		writeCmd && termPin && !writeChop ##1 termPin [*4] ##1 !termPin
		|=> holdViolation)
		else $error("long write hold not flagged");

	c_sync_on: cover property (@(posedge clk) disable iff (rst)
		syncMode && $rose(termEnable));
	c_async_on: cover property (@(posedge clk) disable iff (rst)
		!syncMode && $rose(termEnable));
	c_hold_err: cover property (@(posedge clk) disable iff (rst)
		holdViolation);

endmodule : ddr3_termination_latency_control

`default_nettype wire

/* File: tb/odt_ctrl_model.sv */
// controller model driving the termination pin and write commands
`timescale 1ns/1ps
`default_nettype none

module odt_ctrl_model (
	input wire logic clk,
	output logic termPin,
	output logic writeCmd,
	output logic writeChop
);
	// pin low and no write until a burst is asked for
	initial begin
		termPin = 1'b0;
		writeCmd = 1'b0;
		writeChop = 1'b0;
	end

	// pin high for len edges, write at offset wrOff; callers size len
	// to cover both holds and cut it short only on purpose
	// no reads are issued, so the pin never overlaps one
	task automatic burst(input int len, input int wrOff, input logic chop);
		for (int i = 0; i < len; i++) begin
			termPin <= 1'b1;
			writeCmd <= (i == wrOff);
			writeChop <= chop;
			@(posedge clk);
		end
		termPin <= 1'b0;
		writeCmd <= 1'b0;
	endtask : burst
endmodule : odt_ctrl_model

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the termination latency control block
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import odt_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic prechargePd = 1'b0;
	logic dllLocked = 1'b0;
	mode_regs_t modeRegs = '0;
	wire logic termPin, writeCmd, writeChop;
	logic termEnable, syncMode, holdViolation;
	logic [2:0] termStrength;
	int nMismatch = 0;
	int testsRun = 0;

	always #5 clk = ~clk;

	odt_ctrl_model ctrl (.clk(clk), .termPin(termPin),
		.writeCmd(writeCmd), .writeChop(writeChop));

	ddr3_termination_latency_control dut (.clk(clk), .rst(rst),
		.termPin(termPin), .writeCmd(writeCmd), .writeChop(writeChop),
		.prechargePd(prechargePd), .dllLocked(dllLocked),
		.modeRegs(modeRegs), .termEnable(termEnable),
		.termStrength(termStrength), .syncMode(syncMode),
		.holdViolation(holdViolation));

	////////////////////////////////////////////////////////////////////
	// one comparison, counted
	task automatic chk(input logic [2:0] got, exp, input string what);
		testsRun++;
		if (got !== exp) begin
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
			nMismatch++;
		end
	endtask : chk

	// program the mode images, then let the mode flag settle
	task automatic cfg(input int cwl, input logic [1:0] al, input int cl,
		input logic [2:0] code, input logic dll, pd, pdDll);
		@(posedge clk);
		dllLocked <= dll;
		prechargePd <= pd;
		modeRegs.mr0 <= {3'h0, pdDll, 12'h000};
		// bits 9, 6 and 2 carry the code, bits 4 and 3 the al select
		modeRegs.mr1 <= {6'h00, code[2], 2'h0, code[1], 1'h0, al,
			code[0], 2'h0};
		modeRegs.mr2 <= 16'h0000;
		modeRegs.casLat <= 5'(cl);
		modeRegs.casWriteLat <= 4'(cwl);
		repeat (3) @(posedge clk);
		#1;
		chk(syncMode, dll && code != 0 && !(pd && !pdDll), "mode");
	endtask : cfg

	// one pin burst; enable expected lat edges after each pin change
	task automatic pulse(input int len, wrOff, input logic chop,
		input int lat, input logic [2:0] code, input logic viol);
		logic on;
		@(posedge clk);
		fork
			ctrl.burst(len, wrOff, chop);
			for (int n = 1; n <= len + lat + 3; n++) begin
				@(posedge clk);
				#1;
				// mr2 is always zero here, so a zero code means no value
				on = (code != 3'h0) && (n >= 1 + lat) && (n < 1 + len + lat);
				chk(termEnable, on, "enable");
				chk(termStrength, on ? code : 3'h0, "strength");
				chk(holdViolation, viol && n == 1 + len, "hold");
			end
		join
	endtask : pulse

	////////////////////////////////////////////////////////////////////
	// latency over every additive-latency select and several codes
	task automatic tSync();
		int cwl[4] = '{5, 5, 6, 7};
		int cl[4] = '{6, 6, 7, 6};
		int al;
		for (int i = 0; i < 4; i++) begin
			al = (i == 1) ? cl[i] - 1 : (i == 2) ? cl[i] - 2 : 0;
			cfg(cwl[i], 2'(i), cl[i], 3'(2 * i + 1), 1, 0, 0);
			pulse(4, 99, 0, cwl[i] + al - 2, 3'(2 * i + 1), 0);
		end
	endtask : tSync

	// pin and write holds, short and exact, both burst kinds
	task automatic tHold();
		cfg(5, 2'h0, 6, 3'h2, 1, 0, 0);
		pulse(2, 99, 0, 3, 3'h2, 1);
		pulse(6, 1, 0, 3, 3'h2, 1);
		pulse(7, 1, 0, 3, 3'h2, 0);
		pulse(5, 1, 1, 3, 3'h2, 0);
		pulse(4, 1, 1, 3, 3'h2, 1);
	endtask : tHold

	// resync and DLL-off power-down ignore additive latency
	task automatic tAsync();
		// async: the edge that samples the pin also moves the output
		cfg(5, 2'h1, 6, 3'h3, 0, 0, 0);
		pulse(4, 99, 0, 0, 3'h3, 0);
		cfg(5, 2'h1, 6, 3'h3, 1, 1, 0);
		pulse(4, 99, 0, 0, 3'h3, 0);
		cfg(5, 2'h1, 6, 3'h3, 1, 1, 1);
		pulse(4, 99, 0, 8, 3'h3, 0);
	endtask : tAsync

	// nothing programmed: the pin is refused
	task automatic tOff();
		chk({termEnable, syncMode, holdViolation}, 3'h0, "reset");
		cfg(5, 2'h0, 6, 3'h0, 1, 0, 0);
		pulse(4, 99, 0, 3, 3'h0, 0);
	endtask : tOff

	////////////////////////////////////////////////////////////////////
	// print the counts and the verdict, then end the run
	task automatic stopTest();
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stopTest

	// main sequence: reset five cycles, then every scenario
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		tOff();
		tSync();
		tHold();
		tAsync();
		stopTest();
	end

	// the run needs well under a thousand cycles; cut a hang short
	initial begin
		#200000;
		nMismatch++;
		stopTest();
	end
endmodule : tb_top

`default_nettype wire
